// ### rtl/rc_compressor_timing.sv
// top: APB registers, word clock sync and two compressor channels
`timescale 1ns/10ps

// How it works
// - hold code zero skips the hold phase
// - codes 1-11 hold 32 doubling to 32768 clocks
// - codes 12-15 hold 65536 up 32768 per step
// - attack step 4 dB halved per code
// - decay step 1/64 dB halved per code
// - attack field resets to zero
// - per-channel enable bits, cleared means bypass
// - threshold -3 dB down to -24 dB
// - hysteresis 0 to 3 dB below threshold
module rc_compressor_timing (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [rc_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // sample stream
   input wire logic word_clk_pin,
   input wire logic signed [7:0] level_l,
   input wire logic signed [7:0] level_r,
   // gain reduction results
   output logic [31:0] gain_red_l,
   output logic [31:0] gain_red_r
);
   import rc_pkg::*;

   // ----------------------------------------------------------------
   // register storage
   // ----------------------------------------------------------------
   logic [7:0] ctrl_ff, nxt_ctrl;
   logic [3:0] hold_ff, nxt_hold;
   logic [7:0] rate_ff, nxt_rate;
   logic [31:0] prdata_ff, nxt_prdata;
   logic pready_ff, nxt_pready;
   logic pslverr_ff, nxt_pslverr;
   logic setup, access, mapped;
   logic [31:0] rd_word, status;
   logic wclk_s1_ff, wclk_s2_ff, wclk_s3_ff;
   logic word_tick;
   rc_state_t st_l, st_r;

   // byte address of a register index, word aligned
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [7:0] idx);
      return a == {2'b00, idx, 2'b00};
   endfunction

   // ----------------------------------------------------------------
   // word clock: two-stage sync, then rising edge to a tick
   // ----------------------------------------------------------------
   // third stage exists only so the edge detector never sees stage one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wclk_s1_ff <= 1'b0;
         wclk_s2_ff <= 1'b0;
         wclk_s3_ff <= 1'b0;
      end else begin
         wclk_s1_ff <= word_clk_pin;
         wclk_s2_ff <= wclk_s1_ff;
         wclk_s3_ff <= wclk_s2_ff;
      end
   end

   assign word_tick = wclk_s2_ff & ~wclk_s3_ff;

   // ----------------------------------------------------------------
   // apb decode and read mux
   // ----------------------------------------------------------------
   assign setup = psel & ~penable;
   assign access = psel & penable & pready_ff;

   // status: integer dB of each reduction and both phases
   assign status = {12'h000, st_r, st_l,
                    gain_red_r[31:FRAC_W], gain_red_l[31:FRAC_W]};

   // address decode; reserved hold bits always read as zero
   always_comb begin
      mapped = 1'b1;
      rd_word = '0;
      if (hit(paddr, IDX_CMP_CTRL)) begin
         rd_word = {24'h00_0000, ctrl_ff};
      end else if (hit(paddr, IDX_HOLD_CFG)) begin
         rd_word = {25'h000_0000, hold_ff, 3'b000};
      end else if (hit(paddr, IDX_RATE_CFG)) begin
         rd_word = {24'h00_0000, rate_ff};
      end else if (hit(paddr, IDX_STATUS)) begin
         rd_word = status;
      end else begin
         mapped = 1'b0;
      end
   end

   // next register values; the answer is prepared in the setup cycle
   // so that pready and prdata leave flops with no wait states
   always_comb begin
      nxt_ctrl = ctrl_ff;
      nxt_hold = hold_ff;
      nxt_rate = rate_ff;
      nxt_pready = setup;
      nxt_pslverr = setup & ~mapped;
      nxt_prdata = prdata_ff;
      if (setup) begin
         nxt_prdata = pwrite ? 32'h0000_0000 : rd_word;
      end
      if (access && pwrite) begin
         if (hit(paddr, IDX_CMP_CTRL)) begin
            nxt_ctrl = {1'b0, pwdata[6:0]};
         end else if (hit(paddr, IDX_HOLD_CFG)) begin
            // reserved bits are dropped, whatever the host writes
            nxt_hold = pwdata[HOLD_LSB +: 4];
         end else if (hit(paddr, IDX_RATE_CFG)) begin
            nxt_rate = pwdata[7:0];
         end
      end
   end

   // register file and bus answer flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= CMP_CTRL_RST;
         hold_ff <= HOLD_RST;
         rate_ff <= RATE_RST;
         prdata_ff <= '0;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         ctrl_ff <= nxt_ctrl;
         hold_ff <= nxt_hold;
         rate_ff <= nxt_rate;
         prdata_ff <= nxt_prdata;
         pready_ff <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;

   // ----------------------------------------------------------------
   // channels
   // ----------------------------------------------------------------
   rc_channel u_left (
      .pclk(pclk),
      .presetn(presetn),
      .enable(ctrl_ff[EN_L_BIT]),
      .thr_code(ctrl_ff[THR_LSB +: 3]),
      .hyst_code(ctrl_ff[1:0]),
      .hold_code(hold_ff),
      .atk_code(rate_ff[ATK_LSB +: 4]),
      .dec_code(rate_ff[DEC_LSB +: 4]),
      .word_tick(word_tick),
      .level(level_l),
      .reduction(gain_red_l),
      .state(st_l)
   );

   rc_channel u_right (
      .pclk(pclk),
      .presetn(presetn),
      .enable(ctrl_ff[EN_R_BIT]),
      .thr_code(ctrl_ff[THR_LSB +: 3]),
      .hyst_code(ctrl_ff[1:0]),
      .hold_code(hold_ff),
      .atk_code(rate_ff[ATK_LSB +: 4]),
      .dec_code(rate_ff[DEC_LSB +: 4]),
      .word_tick(word_tick),
      .level(level_r),
      .reduction(gain_red_r),
      .state(st_r)
   );

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_attack_reset;
      @(posedge pclk) disable iff (!presetn)
      !$past(presetn) |-> rate_ff[ATK_LSB +: 4] == 4'h0;
   endproperty
   a_attack_reset: assert property (p_attack_reset)
      else $error("attack field not zero after reset");

   property p_rate_write;
      @(posedge pclk) disable iff (!presetn)
      access && pwrite && hit(paddr, IDX_RATE_CFG) |=>
         rate_ff == $past(pwdata[7:0]);
   endproperty
   a_rate_write: assert property (p_rate_write)
      else $error("rate register write lost");

   property p_hold_rsv;
      @(posedge pclk) disable iff (!presetn)
      setup && !pwrite && hit(paddr, IDX_HOLD_CFG) |=>
         prdata[7] == 1'b0 && prdata[2:0] == 3'b000 &&
         prdata[6:3] == $past(hold_ff);
   endproperty
   a_hold_rsv: assert property (p_hold_rsv)
      else $error("hold register read back wrong");

   property p_ready;
      @(posedge pclk) disable iff (!presetn)
      setup |=> pready ##1 !pready;
   endproperty
   a_ready: assert property (p_ready)
      else $error("apb answer not one access cycle");

   property p_hold_write;
      @(posedge pclk) disable iff (!presetn)
      access && pwrite && hit(paddr, IDX_HOLD_CFG) |=>
         hold_ff == $past(pwdata[6:3]);
   endproperty
   a_hold_write: assert property (p_hold_write)
      else $error("hold code write lost");

   property p_unmapped;
      @(posedge pclk) disable iff (!presetn)
      setup && !mapped |=> pready && pslverr && prdata == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped access not refused");

   property p_tick_pulse;
      @(posedge pclk) disable iff (!presetn)
      word_tick |=> !word_tick;
   endproperty
   a_tick_pulse: assert property (p_tick_pulse)
      else $error("word tick longer than one cycle");

endmodule

// ### rtl/rc_pkg.sv
// package: constants, types and helpers for the range compressor timing
package rc_pkg;

   // ----------------------------------------------------------------
   // register indexes (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_CMP_CTRL = 8'h44;
   localparam logic [7:0] IDX_HOLD_CFG = 8'h45;
   localparam logic [7:0] IDX_RATE_CFG = 8'h46;
   localparam logic [7:0] IDX_STATUS = 8'h50;
   localparam int ADDR_W = 12;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int EN_L_BIT = 6;
   localparam int EN_R_BIT = 5;
   localparam int THR_LSB = 2;
   localparam int HOLD_LSB = 3;
   localparam int ATK_LSB = 4;
   localparam int DEC_LSB = 0;
   localparam int ST_L_LSB = 16;
   localparam int ST_R_LSB = 18;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] CMP_CTRL_RST = 8'h0F;
   localparam logic [3:0] HOLD_RST = 4'h7;
   localparam logic [7:0] RATE_RST = 8'h00;

   // ----------------------------------------------------------------
   // gain arithmetic: dB in fixed point with 24 fraction bits
   // ----------------------------------------------------------------
   localparam int FRAC_W = 24;
   localparam logic [31:0] BASE_ATTACK_STEP = 32'h0400_0000; // 4 dB
   localparam logic [31:0] BASE_DECAY_STEP = 32'h0004_0000; // 1/64 dB
   localparam logic [17:0] HOLD_BASE = 18'h0_0020; // 32 word clocks
   localparam logic [17:0] HOLD_LIN = 18'h0_8000; // 32768 per code
   localparam logic [17:0] HOLD_LIN0 = 18'h1_0000; // 65536 at code 12
   localparam logic [3:0] HOLD_LIN_CODE = 4'hC;

   // compressor phase of one channel
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ATTACK = 2'b01,
      ST_HOLD = 2'b10,
      ST_DECAY = 2'b11
   } rc_state_t;

   // hold length in word clocks; zero means no hold phase
   function automatic logic [17:0] hold_len(input logic [3:0] code);
      if (code == 4'h0) begin
         return 18'h0_0000;
      end else if (code < HOLD_LIN_CODE) begin
         return HOLD_BASE << (code - 4'h1);
      end else begin
         return HOLD_LIN0 + HOLD_LIN * 18'(code - HOLD_LIN_CODE);
      end
   endfunction

   // threshold in whole dB: -3 dB at code 0, 3 dB per step down
   function automatic logic signed [7:0] thr_db(input logic [2:0] code);
      return 8'(-8'sd3 - 8'sd3 * $signed({5'b0_0000, code}));
   endfunction

endpackage

// ### rtl/rc_channel.sv
// one compressor channel: attack, hold and decay of gain reduction
`timescale 1ns/10ps
module rc_channel (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // settings
   input wire logic enable,
   input wire logic [2:0] thr_code,
   input wire logic [1:0] hyst_code,
   input wire logic [3:0] hold_code,
   input wire logic [3:0] atk_code,
   input wire logic [3:0] dec_code,
   // sample stream
   input wire logic word_tick,
   input wire logic signed [7:0] level,
   // results
   output logic [31:0] reduction,
   output rc_pkg::rc_state_t state
);
   import rc_pkg::*;

   logic [31:0] red_ff, nxt_red;
   rc_state_t st_ff, nxt_st;
   logic [17:0] cnt_ff, nxt_cnt;
   logic signed [7:0] thr8;
   logic signed [8:0] lvl9, thr9, low9, diff9;
   logic over, under;
   logic [31:0] target, atk_step, dec_step;
   logic [32:0] sum;

   // ----------------------------------------------------------------
   // level compare and step sizes
   // ----------------------------------------------------------------
   assign lvl9 = {level[7], level};
   // a function result cannot be bit-selected, so it lands in a net first
   assign thr8 = thr_db(thr_code);
   assign thr9 = {thr8[7], thr8};
   assign low9 = thr9 - $signed({7'b000_0000, hyst_code});
   assign diff9 = lvl9 - thr9;
   assign over = diff9 > 9'sd0;
   assign under = lvl9 < low9; // band between keeps the phase
   assign target = {diff9[7:0], 24'h00_0000};
   assign atk_step = BASE_ATTACK_STEP >> atk_code;
   assign dec_step = BASE_DECAY_STEP >> dec_code;
   assign sum = {1'b0, red_ff} + {1'b0, atk_step};

   // next phase, reduction and hold count; moves on word clocks, and clears at once when disabled
   always_comb begin
      nxt_red = red_ff;
      nxt_st = st_ff;
      nxt_cnt = cnt_ff;
      if (!enable) begin
         nxt_red = '0;
         nxt_st = ST_IDLE;
         nxt_cnt = '0;
      end else if (word_tick) begin
         if (over) begin
            nxt_st = ST_ATTACK;
            if (red_ff < target) begin
               // clamp so the reduction never overshoots the excess
               nxt_red = (sum > {1'b0, target}) ? target : sum[31:0];
            end
         end else if (under) begin
            case (st_ff)
               ST_ATTACK: begin
                  if (red_ff == '0) begin
                     nxt_st = ST_IDLE;
                  end else if (hold_code == 4'h0) begin
                     nxt_st = ST_DECAY;
                  end else begin
                     nxt_st = ST_HOLD;
                     nxt_cnt = hold_len(hold_code) - 18'h0_0001;
                  end
               end
               ST_HOLD: begin
                  if (cnt_ff == '0) begin
                     nxt_st = ST_DECAY;
                  end else begin
                     nxt_cnt = cnt_ff - 18'h0_0001;
                  end
               end
               ST_DECAY: begin
                  if (red_ff > dec_step) begin
                     nxt_red = red_ff - dec_step;
                  end else begin
                     nxt_red = '0;
                     nxt_st = ST_IDLE;
                  end
               end
               default: begin
                  nxt_st = ST_IDLE;
               end
            endcase
         end
      end
   end

   // state registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         red_ff <= '0;
         st_ff <= ST_IDLE;
         cnt_ff <= '0;
      end else begin
         red_ff <= nxt_red;
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
      end
   end

   assign reduction = red_ff;
   assign state = st_ff;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_bypass;
      @(posedge pclk) disable iff (!presetn)
      !enable |=> red_ff == '0 && st_ff == ST_IDLE;
   endproperty
   a_bypass: assert property (p_bypass)
      else $error("disabled channel kept gain reduction");

   property p_hold_off;
      @(posedge pclk) disable iff (!presetn)
      enable && word_tick && under && st_ff == ST_ATTACK &&
      red_ff != '0 && hold_code == 4'h0 |=> st_ff == ST_DECAY;
   endproperty
   a_hold_off: assert property (p_hold_off)
      else $error("hold code zero did not skip hold");

   property p_hold_len;
      @(posedge pclk) disable iff (!presetn)
      $rose(st_ff == ST_HOLD) |->
         cnt_ff == hold_len(hold_code) - 18'h0_0001;
   endproperty
   a_hold_len: assert property (p_hold_len)
      else $error("hold count loaded with wrong length");

   property p_hold_keep;
      @(posedge pclk) disable iff (!presetn)
      st_ff == ST_HOLD && enable && !(word_tick && over) |=>
         $stable(red_ff);
   endproperty
   a_hold_keep: assert property (p_hold_keep)
      else $error("gain changed during hold");

   property p_decay;
      @(posedge pclk) disable iff (!presetn)
      st_ff == ST_DECAY && enable && word_tick && under &&
      red_ff > dec_step |=> red_ff == $past(red_ff) - $past(dec_step);
   endproperty
   a_decay: assert property (p_decay)
      else $error("decay step wrong");

   property p_threshold;
      @(posedge pclk) disable iff (!presetn)
      enable && word_tick && red_ff == '0 |=>
         (red_ff != '0) == $past(lvl9 > thr9);
   endproperty
   a_threshold: assert property (p_threshold)
      else $error("attack not started at threshold");

   property p_hyst;
      @(posedge pclk) disable iff (!presetn)
      enable && word_tick && st_ff == ST_ATTACK && !over &&
      lvl9 >= low9 |=> st_ff == ST_ATTACK;
   endproperty
   a_hyst: assert property (p_hyst)
      else $error("left attack inside hysteresis band");

endmodule

// ### testbench/rc_host_model.sv
// apb host model that programs the range compressor registers
`timescale 1ns/10ps
module rc_host_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb master side
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [rc_pkg::ADDR_W-1:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // raised when the slave never answers
   output logic hung
);
   import rc_pkg::*;

   // idle bus from time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      hung = 1'b0;
   end

   // one transfer; the leading edge keeps back-to-back calls apart
   task automatic xfer(input logic wr, input logic [7:0] idx,
         input logic [31:0] wd, output logic [31:0] rd, output logic err);
      int n;
      logic [31:0] d;
      d = wd;
      if (idx == IDX_HOLD_CFG) begin
         d = wd & 32'h0000_0078;
      end
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= ADDR_W'({idx, 2'b00});
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      // bounded wait, request held steady meanwhile
      while (pready !== 1'b1 && n < 50) begin
         n++;
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      if (n >= 50) begin
         hung <= 1'b1;
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule

// ### testbench/tb_rc_compressor_timing.sv
// self-checking bench for the range compressor timing block
`timescale 1ns/10ps
module tb_rc_compressor_timing;
   import rc_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hung;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, gain_red_l, gain_red_r, rdat;
   logic word_clk_pin, rerr;
   logic signed [7:0] level_l, level_r;
   int miscompares = 0;
   int n_tests = 0;

   rc_compressor_timing dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .word_clk_pin(word_clk_pin), .level_l(level_l), .level_r(level_r),
      .gain_red_l(gain_red_l), .gain_red_r(gain_red_r));
   rc_host_model host (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .hung(hung));

   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen,
         input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic w(input logic [7:0] idx, input logic [31:0] d);
      logic [31:0] x;
      logic e;
      host.xfer(1'b1, idx, d, x, e);
   endtask

   task automatic r(input logic [7:0] idx);
      host.xfer(1'b0, idx, 32'h0000_0000, rdat, rerr);
   endtask

   // one word clock, high 3 and low 4 pclk periods
   task automatic tick();
      @(posedge pclk);
      word_clk_pin <= 1'b1;
      repeat (3) @(posedge pclk);
      word_clk_pin <= 1'b0;
      repeat (4) @(posedge pclk);
   endtask

   // disable both channels to clear gain, then set the new control
   task automatic setup(input logic [7:0] ctl, input logic [7:0] rate);
      w(IDX_CMP_CTRL, 32'h0000_0000);
      w(IDX_RATE_CFG, {24'h00_0000, rate});
      w(IDX_CMP_CTRL, {24'h00_0000, ctl});
   endtask

   // -------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------
   task automatic t_regs();
      r(IDX_CMP_CTRL);
      chk("ctrl reset", rdat, 32'h0000_000F);
      r(IDX_HOLD_CFG);
      chk("hold reset", rdat, 32'h0000_0038);
      r(IDX_RATE_CFG);
      chk("rate reset", rdat, 32'h0000_0000);
      w(IDX_HOLD_CFG, 32'h0000_0078);
      r(IDX_HOLD_CFG);
      chk("hold code 15", rdat, 32'h0000_0078);
      w(IDX_RATE_CFG, 32'h0000_00A5);
      r(IDX_RATE_CFG);
      chk("rate rw", rdat, 32'h0000_00A5);
      r(8'h47);
      chk("unmapped err", {31'h0, rerr}, 32'h0000_0001);
      chk("unmapped data", rdat, 32'h0000_0000);
      $display("test regs done");
   endtask

   // every attack code, one tick far above threshold
   task automatic t_attack();
      for (int k = 0; k < 16; k++) begin
         setup(8'h40, {4'(k), 4'h0});
         level_l <= 8'sd20;
         tick();
         chk("attack step", gain_red_l, 32'h0400_0000 >> k);
         chk("right bypass", gain_red_r, 32'h0000_0000);
      end
      setup(8'h20, 8'h00);
      level_r <= 8'sd20;
      tick();
      chk("right step", gain_red_r, 32'h0400_0000);
      chk("left bypass", gain_red_l, 32'h0000_0000);
      $display("test attack done");
   endtask

   // level one dB above each threshold gives a one dB reduction
   task automatic t_thresh();
      for (int c = 0; c < 8; c++) begin
         setup({3'b010, 3'(c), 2'b00}, 8'h00);
         level_l <= 8'(-2 - 3 * c);
         tick();
         chk("threshold", gain_red_l, 32'h0100_0000);
      end
      $display("test threshold done");
   endtask

   // hold keeps gain steady for its length, then decay steps down
   task automatic t_hold(input int code, input int dec);
      int n;
      logic [31:0] g, s, lo;
      n = (code == 0) ? 0 : (32 << (code - 1));
      s = 32'h0004_0000 >> dec;
      w(IDX_HOLD_CFG, {25'h0, 4'(code), 3'b000});
      setup(8'h40, {4'h0, 4'(dec)});
      level_l <= 8'sd20;
      tick();
      tick();
      level_l <= -8'sd50;
      for (int i = 0; i < n; i++) begin
         tick();
      end
      if (n > 0) begin
         chk("hold steady", gain_red_l, 32'h0800_0000);
      end else begin
         tick();
      end
      repeat (4) tick();
      // with a hold, its last tick only ends it: one decay step fewer
      lo = (n > 0) ? 32'h0800_0000 - 3 * s : 32'h0800_0000 - 4 * s;
      chk("decay start", gain_red_l, lo);
      g = gain_red_l;
      tick();
      chk("decay step", g - gain_red_l, s);
      $display("test hold code %0d done", code);
   endtask

   // level inside the band keeps attack, just below enters hold
   task automatic t_hyst();
      w(IDX_HOLD_CFG, 32'h0000_0008);
      for (int h = 0; h < 4; h++) begin
         setup({6'b010000, 2'(h)}, 8'h00);
         level_l <= 8'sd20;
         tick();
         level_l <= 8'(-3 - h);
         tick();
         r(IDX_STATUS);
         chk("in band", {30'h0, rdat[17:16]}, 32'h0000_0001);
         level_l <= 8'(-4 - h);
         tick();
         r(IDX_STATUS);
         chk("below band", {30'h0, rdat[17:16]}, 32'h0000_0002);
      end
      $display("test hysteresis done");
   endtask

   // -------------------------------------------------------------
   // clock, reset, sequence and watchdogs
   // -------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   initial begin
      presetn = 1'b0;
      word_clk_pin = 1'b0;
      level_l = 8'sd0;
      level_r = 8'sd0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_attack();
      t_thresh();
      t_hold(0, 0);
      t_hold(1, 3);
      t_hold(2, 15);
      t_hold(5, 7);
      t_hyst();
      end_of_test();
   end

   // a stuck bus or an overlong run ends in the same report
   always @(posedge hung) begin
      miscompares++;
      end_of_test();
   end

   initial begin
      repeat (90000) @(posedge pclk);
      miscompares++;
      end_of_test();
   end
endmodule
